// ==== tb/i2rs_properties.sv ====
// Concurrent checks on the two-wire link between the master and device ends.
// Assumes the master only ever addresses the device beside it.
`timescale 1ns/1ps
module i2rs_properties (
  // Clocking
  input wire logic clock,
  input wire logic rst_b,
  // Link
  input wire logic sdaDevOe,
  input wire logic scl,
  input wire logic sda
);
  logic sclQ, sdaQ, busy, ninth;
  logic [3:0] bitCnt, byteIdx;
  logic [11:0] oeRun;
  wire sclRise = scl & ~sclQ;
  wire startEv = scl & sclQ & sdaQ & ~sda;
  wire stopEv = scl & sclQ & ~sdaQ & sda;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // ---------------------------------------------------------------
  // Bus tracking
  // ---------------------------------------------------------------
  // Position since the last START; a repeated START restarts the count
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      busy <= 1'b0;
      ninth <= 1'b0;
      bitCnt <= 4'h0;
      byteIdx <= 4'h0;
      oeRun <= 12'h000;
    end else begin
      sclQ <= scl;
      sdaQ <= sda;
      oeRun <= sdaDevOe ? oeRun + 12'h001 : 12'h000;
      ninth <= scl & (ninth | (sclRise & (bitCnt == 4'h8)));
      if (startEv | stopEv) begin
        busy <= startEv;
        bitCnt <= 4'h0;
        byteIdx <= 4'h0;
      end else if (sclRise) begin
        bitCnt <= (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
        byteIdx <= (bitCnt == 4'h8) ? byteIdx + 4'h1 : byteIdx;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_addr_ack: assert property (sclRise && bitCnt == 4'h8 && byteIdx == 4'h0 |-> !sda)
    else $error("address byte not acknowledged");
  a_addr_listen: assert property (sclRise && bitCnt != 4'h8 && byteIdx == 4'h0 |-> !sdaDevOe)
    else $error("device drove during address bits");
  a_ack_hold: assert property (ninth && !sda |=> !scl || !sda)
    else $error("acknowledge released while clock high");
  a_nack_hold: assert property (ninth && sda |=> !scl || sda)
    else $error("not-acknowledge pulled low while clock high");
  a_dev_scl_low: assert property ($changed(sdaDevOe) |-> !scl)
    else $error("device changed data while clock high");
  a_idle_clock: assert property (!busy |-> scl)
    else $error("clock low outside a frame");
  a_idle_quiet: assert property (!busy |-> !sdaDevOe)
    else $error("device drove outside a frame");
  a_stop_aligned: assert property (stopEv |-> bitCnt == 4'h1)
    else $error("stop not on a byte boundary");
  a_oe_bounded: assert property (oeRun <= 12'hb54)
    else $error("device held data low past one byte");

  c_restart: cover property (startEv && busy);
  c_reg_nack: cover property (ninth && sda && byteIdx == 4'h2);
  c_stop: cover property (stopEv);
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench: master and device ends joined by the link, driven from the command side.
// Assumes a 125 MHz clock; the link clock comes from the master's own divider.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic cmdValid = 1'b0, cmdRead = 1'b0, wdValid = 1'b0, wrReady = 1'b0;
  logic [7:0] cmdReg = 8'h00, wdData = 8'h00, seed = 8'h4e, wseed = 8'h4e;
  logic [3:0] cmdLen = 4'h1;
  logic cmdReady, wdReady, rdValid, done, nack, wrValid;
  logic [7:0] rdData, wrData;
  logic [3:0] wrReg, regPtr;
  logic [7:0] expReg [16];
  logic [11:0] expQ [$];
  logic [11:0] w;
  int failures = 0, n_compared = 0;

  i2rs_if link ();
  i2rs_master i_i2rs_master (.clock(clock), .rst_b(rst_b), .clkEn(1'b1), .link(link), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdReg(cmdReg), .cmdLen(cmdLen), .wdValid(wdValid),
    .wdReady(wdReady), .wdData(wdData), .rdValid(rdValid), .rdData(rdData), .done(done), .nack(nack));
  i2rs_device i_i2rs_device (.clock(clock), .rst_b(rst_b), .clkEn(1'b1), .link(link), .wrValid(wrValid),
    .wrReady(wrReady), .wrReg(wrReg), .wrData(wrData), .regPtr(regPtr));
  i2rs_properties i_i2rs_properties (.clock(clock), .rst_b(rst_b), .sdaDevOe(link.sdaDevOe), .scl(link.scl),
    .sda(link.sda));

  // ---------------------------------------------------------------
  // Expectation helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Register zero holds the pointer; others advance and wrap
  function automatic logic [3:0] step(input logic [3:0] p);
    return (p == 4'h0) ? 4'h0 : p + 4'h1;
  endfunction

  task automatic final_report;
    $display("failures=%0d n_compared=%0d", failures, n_compared);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One command; write data is fetched and read data checked until done
  task automatic run(input logic rd, input logic [7:0] r, input logic [3:0] n, input logic expNack);
    logic [3:0] p;
    int j, k;
    p = r[3:0];
    j = 0;
    k = 0;
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdRead <= rd;
    cmdReg <= r;
    cmdLen <= n;
    wdValid <= !rd;
    wdData <= seed;
    @(posedge clock);
    cmdValid <= 1'b0;
    while (done !== 1'b1 && k < 30000) begin
      @(negedge clock);
      k++;
      if (rdValid === 1'b1) begin
        j++;
        `CHK(rdData, expReg[p])
        p = (j < n) ? step(p) : p;
      end
      if (wdReady === 1'b1) begin
        j++;
        expReg[p] = wdData;
        expQ.push_back({p, wdData});
        p = step(p);
        seed = lfsr(seed);
        @(posedge clock);
        wdData <= seed;
      end
    end
    if (k >= 30000)
      failures++;
    `CHK(nack, expNack)
    `CHK(cmdReady, 1'b1)
    `CHK(4'(j), expNack ? 4'h0 : n)
    if (!expNack)
      `CHK(regPtr, p)
    @(posedge clock);
    wdValid <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Clock, stalls, stream monitor, sequence
  // ---------------------------------------------------------------
  initial forever #4 clock = ~clock;

  // User side refuses a quarter of the time
  always @(posedge clock) begin
    wseed <= lfsr(wseed);
    wrReady <= wseed[0] | wseed[1];
  end

  // Stored words must match bus writes in order
  always @(negedge clock) begin
    if (rst_b && wrValid && wrReady) begin
      w = (expQ.size() > 0) ? expQ.pop_front() : 12'hxxx;
      `CHK({wrReg, wrData}, w)
    end
  end

  initial begin
    repeat (90000) @(posedge clock);
    failures++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    run(1'b0, 8'h05, 4'h3, 1'b0);
    run(1'b0, 8'h0f, 4'h3, 1'b0);
    run(1'b1, 8'h05, 4'h3, 1'b0);
    run(1'b1, 8'h00, 4'h2, 1'b0);
    run(1'b0, {seed[7:4] | 4'h1, seed[3:0]}, 4'h1, 1'b1);
    repeat (200) @(posedge clock);
    `CHK(expQ.size() == 0, 1'b1)
    final_report();
  end
endmodule

// ==== verilog/i2rs_device.sv ====
// Register device end of the link plus the FIFO that carries written bytes to the user side.
// Assumes the master obeys the framing and that the user side drains the write stream.
`timescale 1ns/1ps
`include "i2rs_map.svh"

// ---------------------------------------------------------------
// Synchronous FIFO
// ---------------------------------------------------------------
module i2rs_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // Clocking
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count
  assign inReady = (count_r < (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Storage needs no reset; only written slots are ever read
  always_ff @(posedge clock) begin
    if (clkEn && push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (clkEn) begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---------------------------------------------------------------
// Device end
// ---------------------------------------------------------------
module i2rs_device (
  // Clocking
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  // Link
  i2rs_if.device link,
  // Write stream: register number and value of each stored byte
  output logic wrValid,
  input wire logic wrReady,
  output logic [3:0] wrReg,
  output logic [7:0] wrData,
  // Current register pointer
  output logic [3:0] regPtr
);
  logic [2:0] sclSync_r;
  logic [2:0] sdaSync_r;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic sdaIn;
  i2rs_pkg::i2rs_dev_state_t state_r;
  logic [3:0] bitCnt_r;
  logic [7:0] rxShift_r;
  logic [7:0] txShift_r;
  logic readMode_r;
  logic sdaLow_r;
  logic [3:0] ptr_r;
  logic [7:0] regs_r [16];
  logic fifoInValid;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPop;
  logic [11:0] fifoOutData;
  logic wrValid_r;
  logic [11:0] wrWord_r;
  logic [3:0] ptrInc;

  // Two flops per pin, then a third stage only for edge finding
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclSync_r <= 3'h7;
      sdaSync_r <= 3'h7;
    end else if (clkEn) begin
      sclSync_r <= {sclSync_r[1:0], link.scl};
      sdaSync_r <= {sdaSync_r[1:0], link.sda};
    end
  end

  // Clock edges and bus conditions
  assign sclRise = sclSync_r[1] && !sclSync_r[2];
  assign sclFall = !sclSync_r[1] && sclSync_r[2];
  assign startSeen = sclSync_r[1] && sclSync_r[2] && !sdaSync_r[1] && sdaSync_r[2]; // RL15
  assign stopSeen = sclSync_r[1] && sclSync_r[2] && sdaSync_r[1] && !sdaSync_r[2]; // RL15
  assign sdaIn = sdaSync_r[1];
  // Register zero is a fixed target, all others step on
  assign ptrInc = (ptr_r == 4'h0) ? ptr_r : ptr_r + 4'h1; // RL6

  // Byte stored only when the stream has room, else it is refused with a NACK
  assign fifoInValid = (state_r == i2rs_pkg::DEV_WDATA) && sclFall && (bitCnt_r == 4'h8);

  // Link sequencer; all edges come from the sampled pins so any rate up to 400 kHz works
  always_ff @(posedge clock or negedge rst_b) begin // RL16
    if (!rst_b) begin
      state_r <= i2rs_pkg::DEV_IDLE;
      bitCnt_r <= 4'h0;
      rxShift_r <= 8'h00;
      txShift_r <= 8'h00;
      readMode_r <= 1'b0;
      sdaLow_r <= 1'b0;
      ptr_r <= 4'h0;
    end else if (clkEn) begin
      if (stopSeen) begin
        state_r <= i2rs_pkg::DEV_IDLE;
        sdaLow_r <= 1'b0;
      end else if (startSeen) begin
        state_r <= i2rs_pkg::DEV_ADDR; // RL18
        bitCnt_r <= 4'h0;
        sdaLow_r <= 1'b0;
      end else begin
        case (state_r)
          i2rs_pkg::DEV_ADDR, i2rs_pkg::DEV_REG, i2rs_pkg::DEV_WDATA: begin
            if (sclRise) begin
              rxShift_r <= {rxShift_r[6:0], sdaIn};
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall && bitCnt_r == 4'h8) begin
              bitCnt_r <= 4'h0;
              if (state_r == i2rs_pkg::DEV_ADDR) begin
                if (rxShift_r[7:1] == `I2RS_SLAVE_ADDR) begin
                  sdaLow_r <= 1'b1; // RL1 RL9 RL13
                  readMode_r <= rxShift_r[0];
                  state_r <= i2rs_pkg::DEV_ADDR_ACK;
                end else begin
                  state_r <= i2rs_pkg::DEV_IGNORE; // RL18
                end
              end else if (state_r == i2rs_pkg::DEV_REG) begin
                if (rxShift_r < `I2RS_REG_COUNT) begin
                  sdaLow_r <= 1'b1; // RL3
                  ptr_r <= rxShift_r[3:0];
                  state_r <= i2rs_pkg::DEV_REG_ACK;
                end else begin
                  state_r <= i2rs_pkg::DEV_IGNORE; // RL3 RL14
                end
              end else if (fifoInReady) begin
                sdaLow_r <= 1'b1; // RL4 RL13
                ptr_r <= ptrInc; // RL5 RL6
                state_r <= i2rs_pkg::DEV_WACK;
              end else begin
                state_r <= i2rs_pkg::DEV_IGNORE; // RL14
              end
            end
          end
          i2rs_pkg::DEV_ADDR_ACK: begin
            if (sclFall) begin
              if (readMode_r) begin
                // Load the byte and put its top bit out at once
                txShift_r <= {regs_r[ptr_r][6:0], 1'b0}; // RL10
                sdaLow_r <= !regs_r[ptr_r][7]; // RL10
                bitCnt_r <= 4'h1;
                state_r <= i2rs_pkg::DEV_RDATA;
              end else begin
                sdaLow_r <= 1'b0;
                state_r <= i2rs_pkg::DEV_REG; // RL2
              end
            end
          end
          i2rs_pkg::DEV_REG_ACK, i2rs_pkg::DEV_WACK: begin
            if (sclFall) begin
              sdaLow_r <= 1'b0;
              state_r <= i2rs_pkg::DEV_WDATA; // RL7
            end
          end
          i2rs_pkg::DEV_RDATA: begin
            if (sclFall) begin
              if (bitCnt_r == 4'h8) begin
                sdaLow_r <= 1'b0; // RL14
                state_r <= i2rs_pkg::DEV_RACK;
              end else begin
                sdaLow_r <= !txShift_r[7]; // RL10
                txShift_r <= {txShift_r[6:0], 1'b0};
                bitCnt_r <= bitCnt_r + 4'h1;
              end
            end
          end
          i2rs_pkg::DEV_RACK: begin
            if (sclRise) begin
              if (!sdaIn) begin
                ptr_r <= ptrInc; // RL11 RL17
                state_r <= i2rs_pkg::DEV_ADDR_ACK;
              end else begin
                state_r <= i2rs_pkg::DEV_IGNORE; // RL12
              end
            end
          end
          i2rs_pkg::DEV_IDLE, i2rs_pkg::DEV_IGNORE: begin
            sdaLow_r <= 1'b0; // RL18
          end
          default: begin
            state_r <= i2rs_pkg::DEV_IDLE;
          end
        endcase
      end
    end
  end

  // Register file; no reset, so only registers already written may be read back
  always_ff @(posedge clock) begin
    if (clkEn && fifoInValid && fifoInReady) begin
      regs_r[ptr_r] <= rxShift_r; // RL4
    end
  end

  // Open-drain data line: only ever pulls low
  assign link.sdaDevOut = 1'b0;
  assign link.sdaDevOe = sdaLow_r;

  i2rs_fifo #(.WIDTH(12), .DEPTH(`I2RS_FIFO_DEPTH)) wrFifo (
    .clock(clock),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData({ptr_r, rxShift_r}),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );

  // Output stage so the stream leaves from flops; refills as soon as the word is taken
  assign fifoPop = fifoOutValid && (!wrValid_r || wrReady);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrValid_r <= 1'b0;
      wrWord_r <= 12'h000;
    end else if (clkEn) begin
      if (fifoPop) begin
        wrValid_r <= 1'b1;
        wrWord_r <= fifoOutData;
      end else if (wrReady) begin
        wrValid_r <= 1'b0;
      end
    end
  end

  assign wrValid = wrValid_r;
  assign wrReg = wrWord_r[11:8];
  assign wrData = wrWord_r[7:0];
  assign regPtr = ptr_r;
endmodule

// ==== verilog/i2rs_if.sv ====
// Two-wire link between the master end and the register device end.
// Both lines are open drain: an enable pulls the line low, otherwise a pull-up holds it high.
`timescale 1ns/1ps
interface i2rs_if;
  logic sclOut;
  logic sclOe;
  logic sdaMstOut;
  logic sdaMstOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic scl;
  logic sda;

  // Wired-AND of the open-drain drivers with an implied pull-up
  assign scl = ~(sclOe & ~sclOut);
  assign sda = ~(sdaMstOe & ~sdaMstOut) & ~(sdaDevOe & ~sdaDevOut);

  modport master (output sclOut, output sclOe, output sdaMstOut, output sdaMstOe, input scl, input sda);
  modport device (output sdaDevOut, output sdaDevOe, input scl, input sda);
endinterface

// ==== verilog/i2rs_map.svh ====
// Constants of the two-wire register access link: addresses, sizes, timing.
// Assumes both ends include it by bare name.
// Behaviour
// RL1 - Device acknowledges its own address after START
// RL2 - Master sends one register byte after write address
// RL3 - Device acknowledges only existing register numbers
// RL4 - Device stores and acknowledges each written byte; the device NACKs the byte and stores nothing when the write FIFO is full
// RL5 - Pointer advances after every written byte
// RL6 - Register zero keeps pointer fixed
// RL7 - Master sends any bytes, ends with STOP
// RL8 - Master reads via register byte, repeated START
// RL9 - Read address after repeated START is acknowledged
// RL10 - Device shifts selected register out, MSB first
// RL11 - Master acknowledges all but last read byte
// RL12 - Master ends read with NACK then STOP
// RL13 - Acknowledge holds data low through ninth clock
// RL14 - Not-acknowledge leaves data released through ninth clock
// RL15 - Data change while clock high is START/STOP
// RL16 - Works at any clock up to 400 kHz
// RL17 - Reads advance pointer, except register zero
// RL18 - Foreign address ignored until next START
`ifndef I2RS_MAP_SVH
`define I2RS_MAP_SVH

// ---------------------------------------------------------------
// Addressing
// ---------------------------------------------------------------
`define I2RS_SLAVE_ADDR 7'h35
`define I2RS_REG_COUNT 8'h10
`define I2RS_REG_RESET 8'h00
`define I2RS_FIFO_DEPTH 16

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define I2RS_CLK_PERIOD_PS 8000
`define I2RS_SCL_PERIOD_NS 2500
// Quarter of the serial clock period, rounded up so the rate never exceeds 400 kHz
`define I2RS_QTR_CYC ((`I2RS_SCL_PERIOD_NS * 1000 / 4 + `I2RS_CLK_PERIOD_PS - 1) / `I2RS_CLK_PERIOD_PS)

`endif

// ==== verilog/i2rs_master.sv ====
// Master end of the link: runs register write and read commands over the two wires.
// Assumes the device acknowledges by the ninth clock and never stretches the clock.
`timescale 1ns/1ps
`include "i2rs_map.svh"
module i2rs_master (
  // Clocking
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  // Link
  i2rs_if.master link,
  // Command
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdRead,
  input wire logic [7:0] cmdReg,
  input wire logic [3:0] cmdLen,
  // Write data
  input wire logic wdValid,
  output logic wdReady,
  input wire logic [7:0] wdData,
  // Read data and completion
  output logic rdValid,
  output logic [7:0] rdData,
  output logic done,
  output logic nack
);
  localparam logic [7:0] QTR = 8'(`I2RS_QTR_CYC);
  logic [1:0] sdaSync_r;
  logic [7:0] tick_r;
  logic qStep;
  logic [1:0] q_r;
  i2rs_pkg::i2rs_hst_state_t state_r;
  i2rs_pkg::i2rs_phase_t phase_r;
  logic [3:0] bitIdx_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic isRead_r;
  logic [7:0] reg_r;
  logic [3:0] left_r;
  logic sclLow_r;
  logic sdaLow_r;
  logic cmdReady_r;
  logic wdReady_r;
  logic rdValid_r;
  logic done_r;
  logic nack_r;

  // Data line comes back through two flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sdaSync_r <= 2'h3;
    end else if (clkEn) begin
      sdaSync_r <= {sdaSync_r[0], link.sda};
    end
  end

  // Quarter-period divider; the clock is made here, so no edge detection is needed
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick_r <= 8'h00;
    end else if (clkEn) begin
      tick_r <= (tick_r == QTR - 8'h01) ? 8'h00 : tick_r + 8'h01;
    end
  end
  assign qStep = (tick_r == QTR - 8'h01) && (state_r != i2rs_pkg::HST_IDLE) && (state_r != i2rs_pkg::HST_WAIT);

  // Command sequencer: START, bytes with their ninth bit, STOP
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= i2rs_pkg::HST_IDLE;
      phase_r <= i2rs_pkg::PH_ADDR_W;
      q_r <= 2'h0;
      bitIdx_r <= 4'h0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      isRead_r <= 1'b0;
      reg_r <= 8'h00;
      left_r <= 4'h0;
      sclLow_r <= 1'b0;
      sdaLow_r <= 1'b0;
      cmdReady_r <= 1'b1;
      wdReady_r <= 1'b0;
      rdValid_r <= 1'b0;
      done_r <= 1'b0;
      nack_r <= 1'b0;
    end else if (clkEn) begin
      wdReady_r <= 1'b0;
      rdValid_r <= 1'b0;
      done_r <= 1'b0;
      case (state_r)
        i2rs_pkg::HST_IDLE: begin
          if (cmdValid) begin
            cmdReady_r <= 1'b0;
            isRead_r <= cmdRead;
            reg_r <= cmdReg;
            left_r <= (cmdLen == 4'h0) ? 4'h1 : cmdLen;
            nack_r <= 1'b0;
            phase_r <= i2rs_pkg::PH_ADDR_W;
            tx_r <= {`I2RS_SLAVE_ADDR, 1'b0};
            q_r <= 2'h0;
            state_r <= i2rs_pkg::HST_START;
          end
        end
        i2rs_pkg::HST_START: begin
          // Release data with clock low, raise clock, then pull data low while it is high;
          // the clock is pulled low only before a repeated START, so an idle bus stays high
          if (qStep) begin
            q_r <= q_r + 2'h1;
            case (q_r)
              2'h0: begin
                sclLow_r <= (phase_r == i2rs_pkg::PH_ADDR_R);
                sdaLow_r <= 1'b0;
              end
              2'h1: sclLow_r <= 1'b0;
              2'h2: sdaLow_r <= 1'b1; // RL8 RL15
              default: begin
                bitIdx_r <= 4'h0;
                state_r <= i2rs_pkg::HST_BYTE;
              end
            endcase
          end
        end
        i2rs_pkg::HST_WAIT: begin
          // Clock left high after the ninth bit while write data is awaited
          if (wdValid && !wdReady_r) begin
            wdReady_r <= 1'b1;
            tx_r <= wdData;
            bitIdx_r <= 4'h0;
            q_r <= 2'h0;
            state_r <= i2rs_pkg::HST_BYTE;
          end
        end
        i2rs_pkg::HST_BYTE: begin
          if (qStep) begin
            q_r <= q_r + 2'h1;
            case (q_r)
              2'h0: begin
                sclLow_r <= 1'b1;
                if (bitIdx_r < 4'h8) begin
                  sdaLow_r <= (phase_r == i2rs_pkg::PH_RDATA) ? 1'b0 : !tx_r[7 - bitIdx_r[2:0]];
                end else begin
                  sdaLow_r <= (phase_r == i2rs_pkg::PH_RDATA) && (left_r != 4'h1); // RL11 RL12 RL13 RL14
                end
              end
              2'h1: sclLow_r <= 1'b0;
              2'h2: begin
                if (bitIdx_r < 4'h8) begin
                  rx_r <= {rx_r[6:0], sdaSync_r[1]};
                end else if (phase_r != i2rs_pkg::PH_RDATA && sdaSync_r[1]) begin
                  nack_r <= 1'b1;
                end
              end
              default: begin
                bitIdx_r <= bitIdx_r + 4'h1;
                if (bitIdx_r == 4'h8) begin
                  bitIdx_r <= 4'h0;
                  q_r <= 2'h0;
                  if (nack_r) begin
                    state_r <= i2rs_pkg::HST_STOP;
                  end else begin
                    case (phase_r)
                      i2rs_pkg::PH_ADDR_W: begin
                        phase_r <= i2rs_pkg::PH_REG;
                        tx_r <= reg_r; // RL2
                      end
                      i2rs_pkg::PH_REG: begin
                        if (isRead_r) begin
                          phase_r <= i2rs_pkg::PH_ADDR_R;
                          tx_r <= {`I2RS_SLAVE_ADDR, 1'b1}; // RL9
                          state_r <= i2rs_pkg::HST_START; // RL8
                        end else begin
                          phase_r <= i2rs_pkg::PH_WDATA;
                          state_r <= i2rs_pkg::HST_WAIT;
                        end
                      end
                      i2rs_pkg::PH_WDATA: begin
                        left_r <= left_r - 4'h1;
                        state_r <= (left_r == 4'h1) ? i2rs_pkg::HST_STOP : i2rs_pkg::HST_WAIT; // RL7
                      end
                      i2rs_pkg::PH_ADDR_R: begin
                        phase_r <= i2rs_pkg::PH_RDATA;
                      end
                      default: begin
                        rdValid_r <= 1'b1;
                        left_r <= left_r - 4'h1;
                        if (left_r == 4'h1) begin
                          state_r <= i2rs_pkg::HST_STOP; // RL12
                        end
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        i2rs_pkg::HST_STOP: begin
          // Data low with clock low, raise clock, then release data while it is high
          if (qStep) begin
            q_r <= q_r + 2'h1;
            case (q_r)
              2'h0: begin
                sclLow_r <= 1'b1;
                sdaLow_r <= 1'b1;
              end
              2'h1: sclLow_r <= 1'b0;
              2'h2: sdaLow_r <= 1'b0; // RL7 RL12 RL15
              default: begin
                done_r <= 1'b1;
                cmdReady_r <= 1'b1;
                state_r <= i2rs_pkg::HST_IDLE;
              end
            endcase
          end
        end
        default: state_r <= i2rs_pkg::HST_IDLE;
      endcase
    end
  end

  // Open-drain drivers only ever pull low
  assign link.sclOut = 1'b0;
  assign link.sclOe = sclLow_r;
  assign link.sdaMstOut = 1'b0;
  assign link.sdaMstOe = sdaLow_r;
  assign cmdReady = cmdReady_r;
  assign wdReady = wdReady_r;
  assign rdValid = rdValid_r;
  assign rdData = rx_r;
  assign done = done_r;
  assign nack = nack_r;
endmodule

// ==== verilog/i2rs_pkg.sv ====
// Types shared by both ends of the register access link.
// Assumes nothing beyond a SystemVerilog compiler.
package i2rs_pkg;

  // ---------------------------------------------------------------
  // Device sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    DEV_IDLE, DEV_ADDR, DEV_ADDR_ACK, DEV_REG, DEV_REG_ACK,
    DEV_WDATA, DEV_WACK, DEV_RDATA, DEV_RACK, DEV_IGNORE
  } i2rs_dev_state_t;

  // ---------------------------------------------------------------
  // Master bit sequencer states and byte phases
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    HST_IDLE, HST_START, HST_WAIT, HST_BYTE, HST_STOP
  } i2rs_hst_state_t;

  typedef enum logic [2:0] {
    PH_ADDR_W, PH_REG, PH_WDATA, PH_ADDR_R, PH_RDATA
  } i2rs_phase_t;

endpackage
